// ---- dpi_top.sv ----
// Purpose: Memory-side pin interface of a DDR/DDR2 SDRAM controller.
// Assumes: Single-beat accesses; one outstanding command; user logic on sys_clk.
// Notes: Power-on reset pin is synchronised, so it takes effect after three edges.
`default_nettype none
module dpi_top
  import dpi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic por_n,
  input wire logic sw_enable,
  // Command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic cmd_chip,
  input wire logic [BA_W-1:0] cmd_bank,
  input wire logic [ADDR_W-1:0] cmd_row,
  input wire logic [ADDR_W-1:0] cmd_col,
  // Write-data port into the buffer
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [DQ_W-1:0] wr_data,
  input wire logic [CB_W-1:0] wr_check,
  input wire logic [DM_W-1:0] wr_mask,
  // Read-data port
  output logic rd_valid,
  output logic [DQ_W-1:0] rd_data,
  output logic [CB_W-1:0] rd_check,
  // Memory pins
  output logic [CLK_PAIRS-1:0] mem_clk_p,
  output logic [CLK_PAIRS-1:0] mem_clk_n,
  output logic [CS_W-1:0] mem_cs_n,
  output logic mem_ras_n,
  output logic mem_cas_n,
  output logic mem_we_n,
  output logic [BA_W-1:0] mem_bank,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [DM_W-1:0] mem_byte_mask,
  output logic mem_byte_mask_oe_n,
  input wire logic [DQ_W-1:0] mem_data_in,
  output logic [DQ_W-1:0] mem_data_out,
  output logic mem_data_oe_n,
  input wire logic [CB_W-1:0] mem_check_byte_in,
  output logic [CB_W-1:0] mem_check_byte_out,
  output logic mem_check_byte_oe_n
);

  // Whole block state
  typedef struct packed {
    dpi_state_e state;
    logic por_meta; // Synchroniser stage one
    logic por_sync; // Synchroniser stage two
    logic [DQ_W+CB_W-1:0] din_meta; // Read bus stage one
    logic [DQ_W+CB_W-1:0] din_sync; // Read bus stage two
    logic clk_ph; // Memory clock phase
    logic [2:0] cnt; // Delay counter
    logic op_write; // Latched command kind
    logic op_chip;
    logic [ADDR_W-1:0] op_col;
    logic cmd_ready;
    logic wr_ready;
    logic rd_valid;
    logic [DQ_W-1:0] rd_data;
    logic [CB_W-1:0] rd_check;
    logic [CLK_PAIRS-1:0] clk_p;
    logic [CLK_PAIRS-1:0] clk_n;
    logic [CS_W-1:0] cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BA_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [DM_W-1:0] mask;
    logic mask_oe_n;
    logic [DQ_W-1:0] dq_out;
    logic [CB_W-1:0] cb_out;
    logic dq_oe_n;
  } dpi_top_s;

  dpi_top_s r;
  dpi_top_s next_r;
  logic fifo_push_ready; // Room flag from the buffer, driven by its registered full flag

  dpi_fifo_if #(.WIDTH(WD_W)) wq ();

  // Reset pin levels; pins float where the memory must not see a drive
  function automatic dpi_top_s reset_levels();
    dpi_top_s s;
    s = '0;
    s.state = ST_RST;
    s.clk_p = CLK_RST;
    s.clk_n = CLK_RST;
    s.cs_n = CS_IDLE;
    s.ras_n = 1'b1;
    s.cas_n = 1'b1;
    s.we_n = 1'b1;
    s.mask = DM_IDLE;
    s.mask_oe_n = 1'b1;
    s.bank = BA_RST;
    s.addr = ADDR_RST;
    s.dq_out = DQ_RST;
    s.cb_out = CB_RST;
    s.dq_oe_n = 1'b1;
    return s;
  endfunction

  // Chip-select decode shared by row and column commands
  function automatic logic [CS_W-1:0] chip_sel(input logic chip);
    chip_sel = ~(CS_W'(1) << chip);
  endfunction

  // User write words enter the buffer directly
  assign wq.push_valid = wr_valid;
  assign wq.push_data = {wr_data, wr_check, wr_mask};
  assign fifo_push_ready = wq.push_ready;
  // Head word is taken only in the write beat
  assign wq.pop_ready = (r.state == ST_XFER) && r.op_write;

  dpi_fifo #(.WIDTH(WD_W), .DEPTH(FIFO_DEPTH)) u_wbuf (
    .sys_clk(sys_clk),
    .srst(srst),
    .fq(wq.buf_side)
  );

  // Next-state logic for the sequencer and all pin levels
  always_comb begin
    next_r = r;
    next_r.por_meta = por_n;
    next_r.por_sync = r.por_meta;
    next_r.din_meta = {mem_data_in, mem_check_byte_in};
    next_r.din_sync = r.din_meta;
    next_r.wr_ready = fifo_push_ready;
    next_r.rd_valid = 1'b0;
    if (!r.por_sync) begin
      // Power-on reset overrides every input except system reset, which wins in the state register
      next_r = reset_levels();
      next_r.por_meta = por_n;
      next_r.por_sync = r.por_meta;
      next_r.din_meta = {mem_data_in, mem_check_byte_in};
      next_r.din_sync = r.din_meta;
    end else begin
      // Free-running memory clocks once out of reset
      next_r.clk_ph = ~r.clk_ph;
      next_r.clk_p = {CLK_PAIRS{next_r.clk_ph}};
      next_r.clk_n = {CLK_PAIRS{~next_r.clk_ph}};
      // Default is a deselect with strobes high, the data bus released and the byte mask driven all-ones
      next_r.cs_n = CS_IDLE;
      next_r.ras_n = 1'b1;
      next_r.cas_n = 1'b1;
      next_r.we_n = 1'b1;
      next_r.mask = DM_IDLE;
      next_r.mask_oe_n = 1'b0;
      next_r.dq_oe_n = 1'b1;
      case (r.state)
        ST_RST: begin
          next_r.state = ST_SAFE;
        end
        ST_SAFE: begin
          // Deselect only, so the memory sees no command at all
          if (sw_enable) begin
            next_r.state = ST_IDLE;
            next_r.cmd_ready = 1'b1;
          end
        end
        ST_IDLE: begin
          if (cmd_valid && r.cmd_ready) begin
            // Row activate on the chosen chip and bank
            next_r.cs_n = chip_sel(cmd_chip);
            next_r.ras_n = 1'b0;
            next_r.bank = cmd_bank;
            next_r.addr = cmd_row;
            next_r.op_write = cmd_write;
            next_r.op_chip = cmd_chip;
            next_r.op_col = cmd_col;
            next_r.cmd_ready = 1'b0;
            next_r.cnt = CNT_ONE;
            next_r.state = ST_WAIT;
          end else if (!sw_enable) begin
            // Software withdrew the enable: fall back to safe idle
            next_r.cmd_ready = 1'b0;
            next_r.state = ST_SAFE;
          end
        end
        ST_WAIT: begin
          // Hold off the column command for the row-to-column time
          if (r.cnt >= RCD_CNT) begin
            next_r.cs_n = chip_sel(r.op_chip);
            next_r.cas_n = 1'b0;
            next_r.we_n = ~r.op_write;
            next_r.addr = r.op_col;
            next_r.cnt = CNT_ZERO;
            next_r.state = ST_XFER;
          end else begin
            next_r.cnt = r.cnt + CNT_ONE;
          end
        end
        ST_XFER: begin
          if (r.op_write) begin
            // Stalls here until the buffer offers a word
            if (wq.pop_valid) begin
              next_r.dq_out = wq.pop_data[WD_DQ_LSB +: DQ_W];
              next_r.cb_out = wq.pop_data[WD_CB_LSB +: CB_W];
              next_r.mask = wq.pop_data[WD_DM_LSB +: DM_W];
              next_r.dq_oe_n = 1'b0;
              next_r.cmd_ready = 1'b1;
              next_r.state = ST_IDLE;
            end
          end else begin
            // Fixed latency, then take the synchronised bus
            if (r.cnt == RD_LAT) begin
              next_r.rd_data = r.din_sync[CB_W +: DQ_W];
              next_r.rd_check = r.din_sync[0 +: CB_W];
              next_r.rd_valid = 1'b1;
              next_r.cmd_ready = 1'b1;
              next_r.state = ST_IDLE;
            end else begin
              next_r.cnt = r.cnt + CNT_ONE;
            end
          end
        end
        default: begin
          next_r.state = ST_RST;
          next_r.cmd_ready = 1'b0;
        end
      endcase
    end
  end

  // State register; system reset loads the same levels as power-on reset
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r <= reset_levels();
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from the state register
  assign cmd_ready = r.cmd_ready;
  assign wr_ready = r.wr_ready;
  assign rd_valid = r.rd_valid;
  assign rd_data = r.rd_data;
  assign rd_check = r.rd_check;
  assign mem_clk_p = r.clk_p;
  assign mem_clk_n = r.clk_n;
  assign mem_cs_n = r.cs_n;
  assign mem_ras_n = r.ras_n;
  assign mem_cas_n = r.cas_n;
  assign mem_we_n = r.we_n;
  assign mem_bank = r.bank;
  assign mem_addr = r.addr;
  assign mem_byte_mask = r.mask;
  assign mem_byte_mask_oe_n = r.mask_oe_n;
  assign mem_data_out = r.dq_out;
  assign mem_data_oe_n = r.dq_oe_n;
  assign mem_check_byte_out = r.cb_out;
  assign mem_check_byte_oe_n = r.dq_oe_n;
endmodule
`default_nettype wire

// ---- dpi_pkg.sv ----
// Purpose: Shared constants and types for the DDR memory pin interface block.
// Assumes: 40 MHz system clock, single-beat accesses, one command at a time.
// Notes: Every width, timing count and reset level used by the logic lives here, except the strobe and output-enable levels.
`default_nettype none
package dpi_pkg;
  // Pin widths
  localparam int DQ_W = 32;
  localparam int CB_W = 8;
  localparam int DM_W = 5;
  localparam int ADDR_W = 14;
  localparam int BA_W = 2;
  localparam int CS_W = 2;
  localparam int CLK_PAIRS = 3;
  // Write-data word layout inside the FIFO: {data, check byte, mask}
  localparam int WD_DM_LSB = 0;
  localparam int WD_CB_LSB = WD_DM_LSB + DM_W;
  localparam int WD_DQ_LSB = WD_CB_LSB + CB_W;
  localparam int WD_W = WD_DQ_LSB + DQ_W;
  localparam int FIFO_DEPTH = 16;
  // Reset and idle pin levels
  localparam logic [CS_W-1:0] CS_IDLE = 2'h3;
  localparam logic [BA_W-1:0] BA_RST = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
  localparam logic [DM_W-1:0] DM_IDLE = 5'h1F;
  localparam logic [DQ_W-1:0] DQ_RST = 32'h0000_0000;
  localparam logic [CB_W-1:0] CB_RST = 8'h00;
  localparam logic [CLK_PAIRS-1:0] CLK_RST = 3'h0;
  // Timing: row-to-column delay and read capture latency
  localparam int SYS_CLK_NS = 25;
  localparam int TRCD_NS = 50;
  localparam logic [2:0] RCD_CNT = 3'((TRCD_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
  localparam logic [2:0] RD_LAT = 3'h3;
  localparam logic [2:0] CNT_ZERO = 3'h0;
  localparam logic [2:0] CNT_ONE = 3'h1;
  // Controller states, one-hot
  typedef enum logic [5:0] {
    ST_RST = 6'h01,
    ST_SAFE = 6'h02,
    ST_IDLE = 6'h04,
    ST_ACT = 6'h08,
    ST_WAIT = 6'h10,
    ST_XFER = 6'h20
  } dpi_state_e;
endpackage
`default_nettype wire

// ---- dpi_fifo_if.sv ----
// Purpose: Carrier for the write-data FIFO between the pin block and its buffer.
// Assumes: One clock domain for both sides.
// Notes: Push side faces the user, pop side faces the pin sequencer.
`default_nettype none
interface dpi_fifo_if #(parameter int WIDTH = 45);
  logic push_valid; // Word offered for storage
  logic push_ready; // Buffer has room
  logic [WIDTH-1:0] push_data;
  logic pop_valid; // Buffer holds a word
  logic pop_ready; // Sequencer takes the head word
  logic [WIDTH-1:0] pop_data;
  modport buf_side (input push_valid, push_data, pop_ready,
                    output push_ready, pop_valid, pop_data);
  modport user_side (output push_valid, push_data, pop_ready,
                     input push_ready, pop_valid, pop_data);
endinterface
`default_nettype wire

// ---- dpi_fifo.sv ----
// Purpose: Synchronous FIFO holding write words until the sequencer drives them.
// Assumes: DEPTH is a power of two.
// Notes: Full and empty are registered so ready and valid come from flops.
`default_nettype none
module dpi_fifo #(
  parameter int WIDTH = 45,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic srst,
  dpi_fifo_if.buf_side fq
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] CNT_FULL = (PW+1)'(DEPTH);
  localparam logic [PW:0] CNT_ONE = (PW+1)'(1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage words
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic full;
    logic empty;
  } dpi_fifo_s;

  dpi_fifo_s r;
  dpi_fifo_s next_r;
  logic do_push;
  logic do_pop;

  assign fq.push_ready = ~r.full;
  assign fq.pop_valid = ~r.empty;
  assign fq.pop_data = r.mem[r.rd_ptr];

  // Next-state: push and pop may happen in the same cycle
  always_comb begin
    next_r = r;
    do_push = fq.push_valid & ~r.full;
    do_pop = fq.pop_ready & ~r.empty;
    if (do_push) begin
      next_r.mem[r.wr_ptr] = fq.push_data;
      next_r.wr_ptr = r.wr_ptr + PW'(1);
    end
    if (do_pop) begin
      next_r.rd_ptr = r.rd_ptr + PW'(1);
    end
    if (do_push && !do_pop) begin
      next_r.count = r.count + CNT_ONE;
    end else if (do_pop && !do_push) begin
      next_r.count = r.count - CNT_ONE;
    end
    next_r.full = (next_r.count == CNT_FULL);
    next_r.empty = (next_r.count == '0);
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r <= '0;
      r.empty <= 1'b1;
    end else begin
      r <= next_r;
    end
  end
endmodule
`default_nettype wire

// ---- dpi_top_sva.sv ----
// Purpose: Pin-level checks for dpi_top
// Assumes: Bound to dpi_top, one clock domain
// Notes: Reset checks carry no disable so they can watch reset itself
`default_nettype none
module dpi_top_sva
  import dpi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic por_n,
  input wire logic sw_enable,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic cmd_write,
  input wire logic cmd_chip,
  input wire logic [BA_W-1:0] cmd_bank,
  input wire logic [ADDR_W-1:0] cmd_row,
  input wire logic [ADDR_W-1:0] cmd_col,
  input wire logic rd_valid,
  input wire logic [CLK_PAIRS-1:0] mem_clk_p,
  input wire logic [CLK_PAIRS-1:0] mem_clk_n,
  input wire logic [CS_W-1:0] mem_cs_n,
  input wire logic mem_ras_n,
  input wire logic mem_cas_n,
  input wire logic mem_we_n,
  input wire logic [BA_W-1:0] mem_bank,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_byte_mask_oe_n,
  input wire logic mem_data_oe_n,
  input wire logic mem_check_byte_oe_n
);
  // Reset dropped while enable stays off
  sequence safe_s;
    srst ##1 (!srst && !sw_enable) [*3];
  endsequence
  // Command handshake
  sequence take_s;
    cmd_valid && cmd_ready;
  endsequence
  AST_RST_CTL: assert property (@(posedge sys_clk)
    srst |=> mem_cs_n == CS_IDLE && mem_ras_n && mem_cas_n && mem_we_n)
    else $error("control pins wrong in reset");
  AST_RST_ADDR: assert property (@(posedge sys_clk)
    srst |=> mem_bank == BA_RST && mem_addr == ADDR_RST) else $error("address not zero in reset");
  AST_RST_HIZ: assert property (@(posedge sys_clk)
    srst |=> mem_byte_mask_oe_n && mem_data_oe_n && mem_check_byte_oe_n)
    else $error("pins driven in reset");
  // Synchroniser needs three edges before the levels apply
  AST_POR: assert property (@(posedge sys_clk)
    !por_n [*4] |-> mem_cs_n == CS_IDLE && mem_data_oe_n && !cmd_ready)
    else $error("power-on reset levels wrong");
  AST_SAFE: assert property (@(posedge sys_clk)
    safe_s |-> !cmd_ready && mem_cs_n == CS_IDLE) else $error("left safe state unenabled");
  AST_ACT: assert property (@(posedge sys_clk) disable iff (srst)
    take_s |=> !mem_ras_n && mem_cas_n && !mem_cs_n[$past(cmd_chip)]
    && mem_cs_n[!$past(cmd_chip)] && mem_bank == $past(cmd_bank) && mem_addr == $past(cmd_row))
    else $error("row activate wrong");
  AST_COL: assert property (@(posedge sys_clk) disable iff (srst)
    take_s |-> ##3 (!mem_cas_n && mem_ras_n && mem_we_n == !$past(cmd_write, 3)
    && mem_addr == $past(cmd_col, 3))) else $error("column command wrong");
  AST_WR: assert property (@(posedge sys_clk) disable iff (srst)
    !mem_data_oe_n |-> !mem_byte_mask_oe_n && !mem_check_byte_oe_n ##1 mem_data_oe_n)
    else $error("write drive wrong");
  AST_RD: assert property (@(posedge sys_clk) disable iff (srst)
    take_s and !cmd_write |-> ##7 rd_valid) else $error("read data late");
  AST_CLK: assert property (@(posedge sys_clk) disable iff (srst)
    cmd_ready && $past(cmd_ready) |-> mem_clk_n == ~mem_clk_p && mem_clk_p != $past(mem_clk_p))
    else $error("memory clock not differential");
endmodule
`default_nettype wire

// ---- dpi_mem_model.sv ----
// Purpose: Behavioural SDRAM beside dpi_top
// Assumes: One stored word, no address decode
// Notes: Idle data flips every cycle so stale values match the stored word only on alternate cycles
`default_nettype none
module dpi_mem_model
  import dpi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [CS_W-1:0] mem_cs_n,
  input wire logic mem_cas_n,
  input wire logic mem_we_n,
  input wire logic [DM_W-1:0] mem_byte_mask,
  input wire logic mem_data_oe_n,
  input wire logic [DQ_W-1:0] mem_data_out,
  input wire logic [CB_W-1:0] mem_check_byte_out,
  output logic [DQ_W-1:0] mem_data_in,
  output logic [CB_W-1:0] mem_check_byte_in
);
  logic [DQ_W-1:0] cell_d = '0; // Stored data word
  logic [CB_W-1:0] cell_c = '0; // Stored check byte
  logic flip = 1'b0; // Idle scramble phase
  int hold = 0; // Cycles left to drive read data
  logic rd_hit; // Read column command on the pins this cycle
  // The design samples the bus launched at the column edge, so the hit itself must drive data
  assign rd_hit = mem_cs_n != CS_IDLE && !mem_cas_n && mem_we_n;
  // Store unmasked bytes, answer reads, scramble when released
  always @(posedge sys_clk) begin
    if (!mem_data_oe_n) begin
      for (int b = 0; b < 4; b++)
        if (!mem_byte_mask[b]) cell_d[8*b+:8] <= mem_data_out[8*b+:8];
      if (!mem_byte_mask[4]) cell_c <= mem_check_byte_out;
    end
    if (rd_hit) hold <= 7;
    else if (hold > 0) hold <= hold - 1;
    flip <= !flip;
    mem_data_in <= (rd_hit || hold > 0 || flip) ? cell_d : ~cell_d;
    mem_check_byte_in <= (rd_hit || hold > 0 || flip) ? cell_c : ~cell_c;
  end
endmodule
`default_nettype wire

// ---- dpi_top_test.sv ----
// Purpose: Self-checking bench for dpi_top
// Assumes: Inputs change on the falling edge
// Notes: Model keeps one word, so each write is read back at once
`default_nettype none
module dpi_top_test
  import dpi_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, srst = 1, por_n = 1, sw_enable = 0, took;
  logic cmd_valid = 0, cmd_write = 0, cmd_chip = 0, wr_valid = 0;
  logic [BA_W-1:0] cmd_bank = '0, mem_bank;
  logic [ADDR_W-1:0] cmd_row = '0, cmd_col = '0, mem_addr;
  logic [DQ_W-1:0] wr_data = '0, rd_data, mem_data_in, mem_data_out, exp_d = '0;
  logic [CB_W-1:0] wr_check = '0, rd_check, mem_check_byte_in, mem_check_byte_out, exp_c = '0;
  logic [DM_W-1:0] wr_mask = '0, mem_byte_mask;
  logic [CLK_PAIRS-1:0] mem_clk_p, mem_clk_n, last_p;
  logic [CS_W-1:0] mem_cs_n;
  logic cmd_ready, wr_ready, rd_valid, mem_ras_n, mem_cas_n, mem_we_n;
  logic mem_byte_mask_oe_n, mem_data_oe_n, mem_check_byte_oe_n;
  int n_fail = 0, num_checks = 0;
  dpi_top DUT (.*);
  dpi_mem_model u_mem (.*);
  initial forever #12.5 sys_clk = ~sys_clk;
  // Value compare, four-state exact
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // A wait ran out of cycles
  task automatic give_up();
    chk(48'h0, 48'h1);
    final_report();
  endtask
  // Word k as {data, check, mask}
  function automatic logic [WD_W-1:0] word(input int k);
    return {{4{8'(k * 37)}} ^ 32'h5A0F_C3A5, 8'(k) ^ 8'h3C, 5'(k * 7)};
  endfunction
  // Track what the memory should now hold
  task automatic expect_word(input int k);
    logic [WD_W-1:0] w;
    w = word(k);
    for (int b = 0; b < 4; b++)
      if (!w[b]) exp_d[8*b+:8] = w[WD_DQ_LSB+8*b+:8];
    if (!w[4]) exp_c = w[WD_CB_LSB+:CB_W];
  endtask
  // Offer one buffer word; hold valid for the caller
  task automatic push(input int k);
    @(negedge sys_clk);
    wr_valid = 1;
    {wr_data, wr_check, wr_mask} = word(k);
    @(posedge sys_clk);
    took = wr_ready;
  endtask
  // Issue one command, held until ready is seen
  task automatic do_cmd(input logic wr, input logic [ADDR_W-1:0] rc);
    int k;
    @(negedge sys_clk);
    wr_valid = 0;
    cmd_valid = 1;
    cmd_write = wr;
    {cmd_bank, cmd_chip} = rc[2:0];
    cmd_row = rc;
    cmd_col = ~rc;
    // Ready seen at a falling edge stands at the next rising edge, where the command is taken
    for (k = 0; k < 60; k++) begin
      if (cmd_ready === 1'b1) break;
      @(negedge sys_clk);
    end
    if (k == 60) give_up();
    @(negedge sys_clk);
    cmd_valid = 0;
  endtask
  // Read back and compare with the tracked image
  task automatic read_back(input logic [ADDR_W-1:0] rc);
    int k;
    do_cmd(0, rc);
    for (k = 0; k < 20; k++) begin
      @(negedge sys_clk);
      if (rd_valid === 1'b1) break;
    end
    if (k == 20) give_up();
    chk({rd_check, rd_data}, {exp_c, exp_d});
  endtask
  task automatic t_reset();
    repeat (4) @(negedge sys_clk);
    chk({mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n}, {CS_IDLE, 3'h7});
    chk({mem_bank, mem_addr}, {BA_RST, ADDR_RST});
    chk({mem_byte_mask_oe_n, mem_data_oe_n, mem_check_byte_oe_n}, 3'h7);
    $display("t_reset done");
  endtask
  task automatic t_safe();
    int k;
    srst = 0;
    repeat (6) @(negedge sys_clk);
    chk({cmd_ready, mem_cs_n}, {1'b0, CS_IDLE});
    sw_enable = 1;
    for (k = 0; k < 10 && cmd_ready !== 1'b1; k++) @(negedge sys_clk);
    if (k == 10) give_up();
    last_p = mem_clk_p;
    @(negedge sys_clk);
    chk({mem_clk_p, mem_clk_n}, {~last_p, last_p});
    $display("t_safe done");
  endtask
  // Fill until refused, drain with write and read, then stall on empty
  task automatic t_buffer();
    int k;
    k = 0;
    do begin
      push(k);
      k++;
    end while (took === 1'b1 && k < 24);
    chk(wr_ready, 1'b0);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      do_cmd(1, 14'(i * 613));
      expect_word(i);
      read_back(14'(i * 613));
    end
    do_cmd(1, 14'h2A55);
    repeat (10) @(negedge sys_clk);
    chk({mem_data_oe_n, cmd_ready, mem_cs_n}, {2'h2, CS_IDLE});
    push(40);
    expect_word(40);
    read_back(14'h15AA);
    $display("t_buffer done");
  endtask
  task automatic t_por();
    int k;
    por_n = 0;
    // Raise the request only once the synchronised reset holds, so no command is half taken
    repeat (3) @(negedge sys_clk);
    cmd_valid = 1;
    repeat (2) @(negedge sys_clk);
    chk({mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_data_oe_n, cmd_ready},
        {CS_IDLE, 5'h1E});
    por_n = 1;
    cmd_valid = 0;
    read_back(14'h0321);
    $display("t_por done");
  endtask
  initial begin
    t_reset();
    t_safe();
    t_buffer();
    t_por();
    final_report();
  end
endmodule
bind dpi_top dpi_top_sva u_sva (.*);
`default_nettype wire
